// file: dv/cicd_checker.sv
// assertions on the detector's ports
`timescale 1ns/1ps
module cicd_checker (
	// clock, reset, controls
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic [1:0] mode_i,
	input wire logic       chan_mask_i,
	input wire logic       err_clr_i,
	input wire logic       init_sel_i,
	// results
	input wire logic       icc_o,
	input wire logic       logout_o,
	input wire logic       csw_store_o,
	input wire logic [6:0] cause_o,
	input wire logic       master_chk_o,
	input wire logic       log_req_o,
	input wire logic       io_irpt_o,
	input wire logic       sel_reset_o,
	input wire logic       timeout_clr_o,
	input wire logic       resp_hold_o,
	input wire logic       resp_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_clr_log;
		timeout_clr_o && !log_req_o ##1 master_chk_o && log_req_o;
	endsequence
	a_stop_log: assert property (
		$rose(icc_o) && !mode_i[1] |-> ##[0:1] (master_chk_o && log_req_o))
		else $error("stop report missing");
	a_chstop_hold: assert property (
		$rose(icc_o) && mode_i == 2'h1 |-> ##[0:1] resp_hold_o)
		else $error("hold missing");
	a_hold_gate: assert property (resp_hold_o && $past(resp_hold_o) |-> !resp_o)
		else $error("response while held");
	a_icc_sticky: assert property (icc_o && !err_clr_i |=> icc_o)
		else $error("check dropped");
	a_cause_icc: assert property (icc_o == (cause_o != 7'h00))
		else $error("cause and check disagree");
	a_to_order: assert property (
		$rose(icc_o) && cause_o[6:5] != 2'h0 && !mode_i[1] |-> s_clr_log)
		else $error("timeout clear order");
	a_proc_irpt: assert property (
		$rose(icc_o) && mode_i == 2'h2 && !chan_mask_i |-> ##[0:1] io_irpt_o)
		else $error("interrupt missing");
	a_proc_logout: assert property (
		$rose(icc_o) && mode_i == 2'h2 && !chan_mask_i |-> ##[0:1] logout_o)
		else $error("logout missing");
	a_mask_logout: assert property (logout_o |-> !$past(chan_mask_i))
		else $error("logout while masked");
	a_csw_store: assert property (
		$rose(icc_o) && mode_i == 2'h2 && init_sel_i |-> ##[0:1] csw_store_o)
		else $error("status word store missing");
	a_dis_reset: assert property (
		$rose(icc_o) && mode_i == 2'h3 |-> ##[0:1] sel_reset_o)
		else $error("selective reset missing");
	a_dis_mask: assert property (sel_reset_o && $past(chan_mask_i) |-> !io_irpt_o)
		else $error("interrupt while masked");
endmodule // cicd_checker
bind cicd_top cicd_checker cicd_checker_inst (.*);

// file: dv/cicd_cu_model.sv
// control unit model driving in tags and bus in
`timescale 1ns/1ps
module cicd_cu_model (
	// bench requests
	input wire logic       clk_i,
	input wire logic [4:0] tags_i,
	input wire logic [7:0] ua_i,
	input wire logic       bad_par_i,
	// interface pins
	output logic     [4:0] in_tags_o,
	output logic     [7:0] bus_o,
	output logic           par_o
);
	logic [7:0] nxt;
	initial bus_o = 8'h5A;
	// bus toggles while no address or status tag
	assign nxt = (tags_i[1] | tags_i[2]) ? ua_i : ~bus_o;
	always @(posedge clk_i) begin
		in_tags_o <= tags_i;
		bus_o <= nxt;
		par_o <= ~^nxt ^ bad_par_i;
	end
endmodule // cicd_cu_model

// file: dv/cicd_top_tb.sv
// self-checking bench for the detector
`timescale 1ns/1ps
module cicd_top_tb;
	logic        clk_i, sys_rst_i, bus_in_par_i, countdown_exp_i, err_clr_i, resp_req_i, bad;
	logic        chan_mask_i;
	logic        icc_o, master_chk_o, log_req_o, logout_o, io_irpt_o, csw_store_o;
	logic        sel_reset_o, timeout_clr_o, resp_hold_o, resp_o;
	logic [1:0]  mode_i;
	logic [4:0]  tags, in_tags_i;
	logic [6:0]  ctl, cause_o;
	logic [7:0]  ua, bus_in_i;
	int          fail_count, cmp_count;
	// ctl, tags before, tags after, bad parity, expiry, wrong address, cause, mode
	logic [24:0] rows [8] = '{
		25'h0000280,
		25'h0400225,
		25'h100200A,
		25'h0A0080F,
		25'h090080E,
		25'h0001313,
		25'h0880056,
		25'h0042159
	};
	cicd_top cicd_top_inst (.*, .sel_out_i(ctl[6]), .adr_out_i(ctl[5]), .unit_sel_i(ctl[4]),
		.chain_sel_i(ctl[3]), .test_sel_i(ctl[2]), .init_sel_i(ctl[1]), .halt_disc_i(ctl[0]),
		.sent_ua_i(8'h3C), .timeout_ind_i(1'b0));
	cicd_cu_model cicd_cu_model_inst (.clk_i(clk_i), .tags_i(tags), .ua_i(ua), .bad_par_i(bad),
		.in_tags_o(in_tags_i), .bus_o(bus_in_i), .par_o(bus_in_par_i));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("%0d mismatches, %0d compares", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic scen(input logic [24:0] r);
		ctl = r[24:18];
		mode_i = r[1:0];
		tags = r[17:13];
		ua = 8'h3C ^ {7'h00, r[5]};
		bad = r[7];
		step(6);
		tags = r[12:8];
		countdown_exp_i = r[6];
		step(1);
		countdown_exp_i = 1'b0;
		step(6);
		chk(cause_o, 7'h01 << r[4:2]);
		chk(7'(icc_o), 7'h01);
		chk(7'(resp_hold_o), 7'(r[1:0] == cicd_pkg::MODE_CH_STOP));
		chk(7'(resp_o), 7'(r[1:0] != cicd_pkg::MODE_CH_STOP));
		ctl = 7'h00;
		tags = 5'h00;
		step(6);
		err_clr_i = 1'b1;
		step(1);
		err_clr_i = 1'b0;
		step(1);
		chk(cause_o, 7'h00);
	endtask
	initial begin
		{ctl, tags, ua, bad, mode_i} = {12'h000, 8'h3C, 3'h0};
		{countdown_exp_i, err_clr_i, resp_req_i, sys_rst_i} = 4'h3;
		{fail_count, cmp_count} = 64'h0;
		chan_mask_i = 1'b0;
		step(16);
		sys_rst_i = 1'b0;
		step(4);
		chk(7'(icc_o), 7'h00);
		foreach (rows[i]) scen(rows[i]);
		// masked channel: no logout, no disable-mode interrupt
		chan_mask_i = 1'b1;
		scen(rows[3]);
		scen(rows[4]);
		complete_run;
	end
	initial begin
		#100000;
		fail_count++;
		complete_run;
	end
endmodule // cicd_top_tb

// file: logic/cicd_pkg.sv
// constants shared by the channel interface check detector
package cicd_pkg;
	// mode switch encodings
	localparam logic [1:0] MODE_STOP    = 2'h0;
	localparam logic [1:0] MODE_CH_STOP = 2'h1;
	localparam logic [1:0] MODE_PROCESS = 2'h2;
	localparam logic [1:0] MODE_DISABLE = 2'h3;
	// inbound tag vector positions
	localparam int TAG_OPL  = 0;
	localparam int TAG_ADR  = 1;
	localparam int TAG_STS  = 2;
	localparam int TAG_SEL  = 3;
	localparam int TAG_SVC  = 4;
	localparam int TAG_W    = 5;
	// cause vector positions
	localparam int CAUSE_PAR  = 0;
	localparam int CAUSE_ADR  = 1;
	localparam int CAUSE_OPL  = 2;
	localparam int CAUSE_SEL  = 3;
	localparam int CAUSE_MULT = 4;
	localparam int CAUSE_TOS  = 5;
	localparam int CAUSE_TOH  = 6;
	localparam int CAUSE_W    = 7;
	// reset values
	localparam logic [7:0] UA_RST    = 8'h00;
	localparam logic [6:0] CAUSE_RST = 7'h00;
endpackage : cicd_pkg

// file: logic/cicd_sync.sv
// two-flop synchroniser for the interface pins
`timescale 1ns/1ps
module cicd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // cicd_sync

// file: logic/cicd_top.sv
// interface control check detector for a selector channel
// Operation
// - bus-in parity error with address/status tag
// - returned unit address mismatch during selection
// - operational-in falls while select-out active
// - select-in on chain or test selection
// - two in tags while operational-in
// - no answer to address-out at timeout
// - operational-in still up at halt timeout
// - clear timeout indicator before stop/log
// - stop mode: master check and log request
// - channel-stop: also hold outbound tag responses
// - process mode: logout, interrupt, status word
// - disable mode: selective reset and interrupt
`timescale 1ns/1ps
module cicd_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// inbound interface pins (asynchronous)
	input  wire logic [4:0]  in_tags_i,
	input  wire logic [7:0]  bus_in_i,
	input  wire logic        bus_in_par_i,
	// channel state, same clock
	input  wire logic        sel_out_i,
	input  wire logic        adr_out_i,
	input  wire logic [7:0]  sent_ua_i,
	input  wire logic        unit_sel_i,
	input  wire logic        chain_sel_i,
	input  wire logic        test_sel_i,
	input  wire logic        init_sel_i,
	input  wire logic        halt_disc_i,
	input  wire logic        countdown_exp_i,
	input  wire logic        timeout_ind_i,
	// control
	input  wire logic [1:0]  mode_i,
	input  wire logic        chan_mask_i,
	input  wire logic        err_clr_i,
	// outbound responses requested by the sequencer
	input  wire logic        resp_req_i,
	// results
	output logic             icc_o,
	output logic [6:0]       cause_o,
	output logic             master_chk_o,
	output logic             log_req_o,
	output logic             logout_o,
	output logic             io_irpt_o,
	output logic             csw_store_o,
	output logic             sel_reset_o,
	output logic             timeout_clr_o,
	output logic             resp_hold_o,
	output logic             resp_o
);
	typedef struct packed {
		logic       icc;
		logic [6:0] cause;
		logic       master_chk;
		logic       log_req;
		logic       logout;
		logic       io_irpt;
		logic       csw_store;
		logic       sel_reset;
		logic       timeout_clr;
		logic       resp_hold;
		logic       resp;
		logic       opl_prev;
		logic       pend_to;
		logic [6:0] pend_cause;
	} cicd_state_s;

	cicd_state_s st_q;
	cicd_state_s st_d;

	logic [4:0] tags_s;
	logic [8:0] bus_s;
	logic [6:0] hit;
	logic       any_hit;
	logic       par_ok;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	cicd_sync #(.W(5)) u_sync_tags (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.d_i       (in_tags_i),
		.q_o       (tags_s)
	);

	cicd_sync #(.W(9)) u_sync_bus (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.d_i       ({bus_in_par_i, bus_in_i}),
		.q_o       (bus_s)
	);

	function automatic logic count_gt1(input logic [4:0] t);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < cicd_pkg::TAG_W; i++) begin
			n = n + {2'h0, t[i]};
		end
		return n > 3'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// detection

	always_comb begin
		// odd parity over bus and parity bit
		par_ok = ^bus_s;
		hit = '0;
		hit[cicd_pkg::CAUSE_PAR] = !par_ok && (tags_s[cicd_pkg::TAG_ADR]
			|| tags_s[cicd_pkg::TAG_STS]);
		hit[cicd_pkg::CAUSE_ADR] = unit_sel_i && tags_s[cicd_pkg::TAG_ADR]
			&& (bus_s[7:0] != sent_ua_i);
		hit[cicd_pkg::CAUSE_OPL] = st_q.opl_prev && !tags_s[cicd_pkg::TAG_OPL]
			&& sel_out_i;
		hit[cicd_pkg::CAUSE_SEL] = adr_out_i && tags_s[cicd_pkg::TAG_SEL]
			&& (chain_sel_i || test_sel_i);
		hit[cicd_pkg::CAUSE_MULT] = tags_s[cicd_pkg::TAG_OPL]
			&& count_gt1(tags_s & ~5'h01);
		hit[cicd_pkg::CAUSE_TOS] = init_sel_i && adr_out_i && countdown_exp_i
			&& !(tags_s[cicd_pkg::TAG_OPL] || tags_s[cicd_pkg::TAG_SEL]
			|| tags_s[cicd_pkg::TAG_STS]);
		hit[cicd_pkg::CAUSE_TOH] = halt_disc_i && countdown_exp_i
			&& tags_s[cicd_pkg::TAG_OPL];
		any_hit = |hit;
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_d = st_q;
		st_d.opl_prev    = tags_s[cicd_pkg::TAG_OPL];
		st_d.master_chk  = 1'b0;
		st_d.log_req     = 1'b0;
		st_d.logout      = 1'b0;
		st_d.io_irpt     = 1'b0;
		st_d.csw_store   = 1'b0;
		st_d.sel_reset   = 1'b0;
		st_d.timeout_clr = 1'b0;
		// clear first; a new hit in the same cycle still sets
		if (err_clr_i) begin
			st_d.icc       = 1'b0;
			st_d.cause     = '0;
			st_d.resp_hold = 1'b0;
		end
		if (any_hit) begin
			st_d.icc   = 1'b1;
			st_d.cause = st_d.cause | hit;
		end
		// report one cycle later so a timeout clear goes out first
		st_d.pend_to    = 1'b0;
		st_d.pend_cause = '0;
		if (any_hit && (hit[cicd_pkg::CAUSE_TOS] || hit[cicd_pkg::CAUSE_TOH])) begin
			st_d.timeout_clr = 1'b1;
			st_d.pend_to     = 1'b1;
			st_d.pend_cause  = hit;
		end
		if ((any_hit && !st_d.pend_to) || st_q.pend_to) begin
			case (mode_i)
				cicd_pkg::MODE_STOP: begin
					st_d.master_chk = 1'b1;
					st_d.log_req    = 1'b1;
				end
				cicd_pkg::MODE_CH_STOP: begin
					st_d.master_chk = 1'b1;
					st_d.log_req    = 1'b1;
					st_d.resp_hold  = 1'b1;
				end
				cicd_pkg::MODE_PROCESS: begin
					st_d.logout    = !chan_mask_i;
					st_d.io_irpt   = 1'b1;
					st_d.csw_store = init_sel_i;
				end
				cicd_pkg::MODE_DISABLE: begin
					st_d.sel_reset = 1'b1;
					st_d.io_irpt   = !chan_mask_i;
				end
				default: begin
					st_d.master_chk = 1'b1;
				end
			endcase
		end
		// outbound responses pass unless frozen
		st_d.resp = resp_req_i && !st_d.resp_hold;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign icc_o         = st_q.icc;
	assign cause_o       = st_q.cause;
	assign master_chk_o  = st_q.master_chk;
	assign log_req_o     = st_q.log_req;
	assign logout_o      = st_q.logout;
	assign io_irpt_o     = st_q.io_irpt;
	assign csw_store_o   = st_q.csw_store;
	assign sel_reset_o   = st_q.sel_reset;
	assign timeout_clr_o = st_q.timeout_clr;
	assign resp_hold_o   = st_q.resp_hold;
	assign resp_o        = st_q.resp;
endmodule // cicd_top
